//--- design/adcc_pkg.sv
package adcc_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL0  = 4'h0;
  localparam logic [3:0] REG_CTRL1  = 4'h1;
  localparam logic [3:0] REG_TEMP   = 4'h2;
  localparam logic [3:0] REG_RESH   = 4'h3;
  localparam logic [3:0] REG_RESL   = 4'h4;
  localparam logic [3:0] REG_PINSH  = 4'h5;

  // Control register 0 fields
  localparam int CTRL0_START_BIT = 7;
  localparam int CTRL0_BUSY_BIT  = 6;
  localparam int CTRL0_PWR_BIT   = 5;
  localparam int CTRL0_CHAN_LSB  = 0;

  // Control register 1 fields
  localparam int CTRL1_SRC_LSB = 5;
  localparam int CTRL1_REF_LSB = 3;
  localparam int CTRL1_CLK_LSB = 0;

  // Temperature sensor control fields
  localparam int TEMP_EN_BIT   = 0;
  localparam int TEMP_RSV_BIT  = 1;

  // Reset values
  localparam logic [7:0] CTRL0_RESET  = 8'h00;
  localparam logic [7:0] CTRL1_RESET  = 8'h00;
  localparam logic [1:0] TEMP_RESET   = 2'h2;
  localparam logic [7:0] PINSH_RESET  = 8'h00;

  // Timing counts in converter clocks
  localparam logic [5:0] SAMPLE_NORMAL = 6'h04;
  localparam logic [5:0] SAMPLE_TEMP   = 6'h2E;
  localparam logic [5:0] CONVERT_CLKS  = 6'h0C;

  // Input source codes
  localparam logic [2:0] SRC_EXT0    = 3'h0;
  localparam logic [2:0] SRC_BANDGAP = 3'h1;
  localparam logic [2:0] SRC_TEMP    = 3'h2;
  localparam logic [2:0] SRC_AMP0    = 3'h3;
  localparam logic [2:0] SRC_AMP1    = 3'h4;
  localparam logic [2:0] SRC_LINE    = 3'h5;
  localparam logic [2:0] SRC_EXT1    = 3'h6;

  // Reference codes
  localparam logic [1:0] REF_PIN    = 2'h0;
  localparam logic [1:0] REF_TEMP   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } adcc_state_e;

endpackage : adcc_pkg

//--- design/adcc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_clk_div (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] divSel,
  // Enable pulse
  output logic            tick
);
  import adcc_pkg::*;

  logic [6:0] cnt_q;
  logic [6:0] lastCnt;

  // Power-of-two divide: terminal count is 2^sel - 1
  assign lastCnt = 7'((8'h01 << divSel) - 8'h01);

  always_ff @(posedge core_clk) begin
    if (rst || !run || cnt_q >= lastCnt) begin
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end

  assign tick = run && (cnt_q >= lastCnt);  // [RULE_06]

endmodule : adcc_clk_div
`default_nettype wire

//--- design/adcc_route.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_route (
  // Selects
  input  wire logic [2:0]  srcSel,
  input  wire logic [1:0]  refSel,
  input  wire logic [3:0]  chanSel,
  input  wire logic        powered,
  // Analog switch controls
  output logic [11:0] extChanOn,
  output logic [4:0]  intSrcOn,
  output logic [2:0]  refOn
);
  import adcc_pkg::*;

  always_comb begin
    extChanOn = 12'h000;
    intSrcOn  = 5'h00;
    refOn     = 3'h0;
    if (powered) begin
      case (srcSel)
        SRC_EXT0, SRC_EXT1: begin
          if (chanSel < 4'hC) begin
            extChanOn[chanSel] = 1'b1;  // [RULE_17]
          end
        end
        SRC_BANDGAP: intSrcOn[0] = 1'b1;  // [RULE_18]
        SRC_TEMP:    intSrcOn[1] = 1'b1;  // [RULE_18]
        SRC_AMP0:    intSrcOn[2] = 1'b1;  // [RULE_18]
        SRC_AMP1:    intSrcOn[3] = 1'b1;  // [RULE_18]
        SRC_LINE:    intSrcOn[4] = 1'b1;  // [RULE_18]
        default:     intSrcOn = 5'h00;
      endcase
      case (refSel)
        REF_PIN:  refOn[0] = 1'b1;  // [RULE_12]
        REF_TEMP: refOn[2] = 1'b1;  // [RULE_12]
        default:  refOn[1] = 1'b1;  // [RULE_12]
      endcase
    end
  end

endmodule : adcc_route
`default_nettype wire

//--- design/adcc_top.sv
// What this block does
// [RULE_01] A high-then-low pulse of the start bit begins one conversion.
// [RULE_02] Busy flag rises by itself once a conversion has started.
// [RULE_03] Busy flag falls back to zero when the conversion finishes.
// [RULE_04] Completion sets the request flag; interrupt only when enabled.
// [RULE_05] Busy flag is readable by software at all times.
// [RULE_06] Converter clock is system clock divided by two to the select code.
// [RULE_07] Software keeps converter clock period within 0.5 to 10 us.
// [RULE_08] Temperature conversions need a 1 to 2 us converter clock.
// [RULE_09] Converter is powered only while the power enable bit is high.
// [RULE_10] Software waits a settling delay after enabling before starting.
// [RULE_11] Software clears power enable when conversions are not needed.
// [RULE_12] Reference code 00 pin, 01 and 11 supply, 10 temperature reference.
// [RULE_13] Software enables the temperature sensor before using its reference.
// [RULE_14] With supply reference, software keeps the reference pin unconfigured.
// [RULE_15] Analog pin selection disables other functions and its pull-high.
// [RULE_16] Analog pin selection overrides the port direction control.
// [RULE_17] Source codes 000 and 110 connect the chosen external channel.
// [RULE_18] Codes 001 to 101 select bandgap, temp, amp0, amp1, line amp.
// [RULE_19] With an internal source, software parks the channel select unused.
// [RULE_20] Software never writes source select code 111.
// [RULE_21] Normal conversion: 4 sampling then 12 converting clocks.
// [RULE_22] Temperature conversion: 46 sampling then 12 converting clocks.
// [RULE_23] Result registers hold the new value once busy goes low.
// [RULE_24] A start pulse while power is off is ignored; busy stays clear.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module adcc_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [7:0]       regRdata,
  // Interrupt handshake with the interrupt controller
  input  wire logic        intEnable,
  input  wire logic        intFlagClr,
  output logic             intFlag,
  output logic             intReq,
  // Converter core
  input  wire logic        cmpOut,
  output logic             convPowerOn,
  output logic             sampleOn,
  output logic [11:0]      dacCode,
  output logic             tempSensorOn,
  // Analog switches
  output logic [11:0]      extChanOn,
  output logic [4:0]       intSrcOn,
  output logic [2:0]       refOn,
  // Pin sharing
  output logic [7:0]       pinAnalog,
  output logic [7:0]       pinPullOff,
  output logic [7:0]       pinDirOverride
);
  import adcc_pkg::*;

  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [1:0]  temp_q;
  logic [7:0]  pinsh_q;
  logic        busy_q;
  logic        flag_q;
  logic [11:0] result_q;
  logic [11:0] sar_q;
  logic [5:0]  cnt_q;
  logic [3:0]  bit_q;
  logic        startSeen_q;
  logic [7:0]  rdata_q;
  adcc_state_e state_q;
  logic        tick;
  logic        wrCtrl0;
  logic        startFall;
  logic        done;
  logic        powered;
  logic [2:0]  srcSel;
  logic [5:0]  sampleLen;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r, input logic s);
    hit = s && (a == r);
  endfunction : hit

  assign powered   = ctrl0_q[CTRL0_PWR_BIT];
  assign srcSel    = ctrl1_q[CTRL1_SRC_LSB +: 3];
  assign wrCtrl0   = hit(regAddr, REG_CTRL0, regWr);
  assign sampleLen = (srcSel == SRC_TEMP) ? SAMPLE_TEMP : SAMPLE_NORMAL;  // [RULE_21] [RULE_22]

  // Register writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl0_q <= CTRL0_RESET;
      ctrl1_q <= CTRL1_RESET;
      temp_q  <= TEMP_RESET;
      pinsh_q <= PINSH_RESET;
    end else begin
      if (wrCtrl0) begin
        ctrl0_q <= regWdata;
      end
      if (hit(regAddr, REG_CTRL1, regWr)) begin
        if (regWdata[CTRL1_SRC_LSB +: 3] == 3'h7) begin
          ctrl1_q[4:0] <= regWdata[4:0];
        end else begin
          ctrl1_q <= regWdata;
        end
      end
      if (hit(regAddr, REG_TEMP, regWr)) begin
        temp_q <= regWdata[1:0];
      end
      if (hit(regAddr, REG_PINSH, regWr)) begin
        pinsh_q <= regWdata;
      end
    end
  end

  // Start edge detection: rising then falling
  always_ff @(posedge core_clk) begin
    if (rst) begin
      startSeen_q <= 1'b0;
    end else if (!powered) begin
      startSeen_q <= 1'b0;  // [RULE_24]
    end else if (wrCtrl0 && regWdata[CTRL0_START_BIT]) begin
      startSeen_q <= 1'b1;
    end else if (startFall) begin
      startSeen_q <= 1'b0;
    end
  end

  assign startFall = startSeen_q && wrCtrl0 && !regWdata[CTRL0_START_BIT]
                     && regWdata[CTRL0_PWR_BIT];  // [RULE_01] [RULE_24]

  adcc_clk_div u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (busy_q),
    .divSel   (ctrl1_q[CTRL1_CLK_LSB +: 3]),
    .tick     (tick)
  );

  // Conversion sequencer
  always_ff @(posedge core_clk) begin
    if (rst || !powered) begin
      state_q  <= ST_IDLE;
      busy_q   <= 1'b0;
      cnt_q    <= 6'h00;
      bit_q    <= 4'h0;
      sar_q    <= 12'h000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (startFall) begin
            state_q <= ST_SAMPLE;
            busy_q  <= 1'b1;  // [RULE_02]
            cnt_q   <= 6'h00;
          end
        end
        ST_SAMPLE: begin
          if (tick) begin
            if (cnt_q == sampleLen - 6'h01) begin
              state_q <= ST_CONV;
              cnt_q   <= 6'h00;
              bit_q   <= 4'hB;
              sar_q   <= 12'h800;
            end else begin
              cnt_q <= cnt_q + 6'h01;
            end
          end
        end
        ST_CONV: begin
          if (tick) begin
            sar_q[bit_q] <= cmpOut;
            if (bit_q != 4'h0) begin
              sar_q[bit_q - 4'h1] <= 1'b1;
              bit_q <= bit_q - 4'h1;
              cnt_q <= cnt_q + 6'h01;
            end else begin
              state_q <= ST_IDLE;
              busy_q  <= 1'b0;  // [RULE_03]
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // Clearing power aborts: no flag and no result from a cut conversion
  assign done = powered && (state_q == ST_CONV) && tick && (bit_q == 4'h0);

  // Result capture, valid when busy drops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      result_q <= 12'h000;
    end else if (done) begin
      result_q <= {sar_q[11:1], cmpOut};  // [RULE_23]
    end
  end

  // Completion request flag, set wins over clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (done) begin
      flag_q <= 1'b1;  // [RULE_04]
    end else if (intFlagClr) begin
      flag_q <= 1'b0;
    end
  end

  assign intFlag = flag_q;
  assign intReq  = flag_q && intEnable;  // [RULE_04]

  // Read path
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL0: rdata_q <= {1'b0, busy_q, ctrl0_q[5:0]};  // [RULE_05]
        REG_CTRL1: rdata_q <= ctrl1_q;
        REG_TEMP:  rdata_q <= {6'h00, temp_q};
        REG_RESH:  rdata_q <= result_q[11:4];
        REG_RESL:  rdata_q <= {result_q[3:0], 4'h0};
        REG_PINSH: rdata_q <= pinsh_q;
        default:   rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign regRdata     = rdata_q;
  assign convPowerOn  = powered;  // [RULE_09]
  assign sampleOn     = (state_q == ST_SAMPLE);
  assign dacCode      = sar_q;
  assign tempSensorOn = temp_q[TEMP_EN_BIT];

  // Pin sharing: analog selection disables pull-high and overrides direction
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign pinAnalog[g]      = pinsh_q[g];  // [RULE_15]
      assign pinPullOff[g]     = pinsh_q[g];  // [RULE_15]
      assign pinDirOverride[g] = pinsh_q[g];  // [RULE_16]
    end
  endgenerate

  adcc_route u_route (
    .srcSel    (srcSel),
    .refSel    (ctrl1_q[CTRL1_REF_LSB +: 2]),
    .chanSel   (ctrl0_q[CTRL0_CHAN_LSB +: 4]),
    .powered   (powered),
    .extChanOn (extChanOn),
    .intSrcOn  (intSrcOn),
    .refOn     (refOn)
  );

  // Assertions
  a_busy_rise: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_02]
    startFall && state_q == ST_IDLE && powered |=> busy_q)
    else $error("busy did not rise after start");

  a_busy_fall: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_03]
    done |=> !busy_q && flag_q)
    else $error("busy did not fall at completion");

  a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_04]
    done |=> intReq == intEnable)
    else $error("interrupt not gated by enable at completion");

  a_flag_cause: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_04]
    $rose(flag_q) |-> $past(done))
    else $error("request flag set without completion");

  a_no_power: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_24]
    !powered |=> !busy_q)
    else $error("busy while powered off");

  a_start_unpowered: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_24]
    wrCtrl0 && regWdata[CTRL0_START_BIT] && !powered |=> !startSeen_q)
    else $error("start accepted while powered off");

  a_result_new: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_23]
    done |=> result_q == $past({sar_q[11:1], cmpOut}))
    else $error("result not captured");

  a_sample_len: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_21] [RULE_22]
    $rose(state_q == ST_CONV) |-> $past(cnt_q) == sampleLen - 6'h01)
    else $error("wrong sampling length");

  a_conv_len: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_21]
    done |-> cnt_q == CONVERT_CLKS - 6'h01)
    else $error("wrong conversion length");

  a_pwr_out: assert property (@(posedge core_clk) disable iff (rst)  // [RULE_09]
    !convPowerOn |-> extChanOn == 12'h000 && refOn == 3'h0)
    else $error("switches on while unpowered");

endmodule : adcc_top
`default_nettype wire

//--- tb/adcc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model (
  // Clock
  input  wire logic        core_clk,
  // Converter core
  input  wire logic        powered,
  input  wire logic        sampleOn,
  input  wire logic [11:0] dacCode,
  input  wire logic [11:0] level,
  output logic             cmpOut
);
  logic [11:0] held_q;
  logic        flip_q = 1'b0;
  // Track the input while sampling, hold it while converting
  always @(posedge core_clk) begin
    flip_q <= ~flip_q;
  end
  always_ff @(posedge core_clk) begin
    if (sampleOn) begin
      held_q <= level;
    end
  end
  // Comparator output, a changing pattern while unpowered
  assign cmpOut = powered ? (held_q >= dacCode) : flip_q;
endmodule : adcc_analog_model
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adcc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWdata = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        intEnable = 1'b0;
  logic        intFlagClr = 1'b0;
  logic [11:0] level = 12'h000;
  logic [7:0]  regRdata;
  logic        intFlag;
  logic        intReq;
  logic        cmpOut;
  logic        convPowerOn;
  logic        sampleOn;
  logic [11:0] dacCode;
  logic        tempSensorOn;
  logic [11:0] extChanOn;
  logic [4:0]  intSrcOn;
  logic [2:0]  refOn;
  logic [7:0]  pinAnalog;
  logic [7:0]  pinPullOff;
  logic [7:0]  pinDirOverride;
  logic [7:0]  expQ[$];
  logic        rdPend = 1'b0;
  logic [7:0]  p;
  int          err_count = 0;
  int          checks_done = 0;

  adcc_top i_dut (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .intEnable(intEnable), .intFlagClr(intFlagClr), .intFlag(intFlag),
    .intReq(intReq), .cmpOut(cmpOut), .convPowerOn(convPowerOn), .sampleOn(sampleOn), .dacCode(dacCode),
    .tempSensorOn(tempSensorOn), .extChanOn(extChanOn), .intSrcOn(intSrcOn), .refOn(refOn),
    .pinAnalog(pinAnalog), .pinPullOff(pinPullOff), .pinDirOverride(pinDirOverride));
  adcc_analog_model i_model (.core_clk(core_clk), .powered(convPowerOn), .sampleOn(sampleOn),
    .dacCode(dacCode), .level(level), .cmpOut(cmpOut));

  always #10 core_clk = ~core_clk;

  task report_and_stop();
    if (err_count == 0 && checks_done > 0 && expQ.size() == 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task cmp(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task cmpRead(input logic [7:0] got, input logic [7:0] exp);
    cmp({4'h0, got}, {4'h0, exp});
  endtask : cmpRead

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask : rd

  // Read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rdPend) begin
      cmpRead(regRdata, expQ.pop_front());
    end
    rdPend <= regRd;
  end

  task conv(input logic [2:0] src, input logic [2:0] clk, input int ns, input logic [3:0] ch);
    logic [11:0] v;
    time         t0;
    int          n;
    int          lim;
    v = 12'($urandom_range(4095, 0));
    level <= v;
    wr(REG_CTRL1, {src, 2'b01, clk});
    wr(REG_CTRL0, 8'h20 | {4'h0, ch});
    repeat (4) @(posedge core_clk);
    wr(REG_CTRL0, 8'hA0 | {4'h0, ch});
    wr(REG_CTRL0, 8'h20 | {4'h0, ch});
    t0 = $time;
    cmp(extChanOn, (src == SRC_EXT0 || src == SRC_EXT1) ? 12'(1 << ch) : 12'h000);
    cmp(12'(refOn), 12'h002);
    rd(REG_CTRL0, 8'h60 | {4'h0, ch});
    lim = (ns + 12) << clk;
    n = 0;
    while (intFlag !== 1'b1 && n < 4000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (intFlag !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    n = int'(($time - t0) / 20);
    cmp(12'(n >= lim - 1 && n <= lim + (1 << clk) + 2), 12'h001);
    cmp(12'(intReq), 12'(intEnable));
    rd(REG_CTRL0, 8'h20 | {4'h0, ch});
    rd(REG_RESH, v[11:4]);
    rd(REG_RESL, {v[3:0], 4'h0});
    @(posedge core_clk);
    intFlagClr <= 1'b1;
    @(posedge core_clk);
    intFlagClr <= 1'b0;
    #1 cmp(12'(intFlag), 12'h000);
  endtask : conv

  initial begin
    void'($urandom(87));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(REG_CTRL0, CTRL0_RESET);
    rd(REG_CTRL1, CTRL1_RESET);
    rd(REG_TEMP, {6'h00, TEMP_RESET});
    rd(REG_PINSH, PINSH_RESET);
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'h00);
    // Start pulse while unpowered
    wr(REG_CTRL0, 8'h80);
    wr(REG_CTRL0, 8'h00);
    rd(REG_CTRL0, 8'h00);
    #1 cmp(12'({convPowerOn, intFlag}), 12'h000);
    intEnable <= 1'b1;
    conv(SRC_EXT0, 3'($urandom_range(7, 5)), 4, 4'($urandom_range(11, 0)));
    intEnable <= 1'b0;
    conv(SRC_EXT1, 3'h1, 4, 4'($urandom_range(11, 0)));
    wr(REG_TEMP, 8'h03);
    #1 cmp(12'(tempSensorOn), 12'h001);
    conv(SRC_TEMP, 3'h6, 46, 4'hC);
    for (int s = 1; s <= 5; s++) begin
      wr(REG_CTRL1, {3'(s), 5'h08});
      #1 cmp({7'h00, intSrcOn}, 12'(1 << (s - 1)));
      cmp(extChanOn, 12'h000);
    end
    wr(REG_CTRL1, 8'hE9);
    rd(REG_CTRL1, 8'hA9);
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL1, {3'h5, 2'(r), 3'h0});
      #1 cmp(12'(refOn), (r == 0) ? 12'h001 : (r == 2) ? 12'h004 : 12'h002);
    end
    p = 8'($urandom());
    wr(REG_PINSH, p);
    #1 cmp({4'h0, pinAnalog}, {4'h0, p});
    cmp({4'h0, pinPullOff}, {4'h0, p});
    cmp({4'h0, pinDirOverride}, {4'h0, p});
    rd(REG_PINSH, p);
    wr(REG_CTRL0, 8'h00);
    #1 cmp(12'({convPowerOn, refOn}), 12'h000);
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
